/* rtl/coef_cfg.svh */
// constants for the coefficient access and bias control register bank
// assumes a control port that hands over page, address and read and write strobes
`ifndef COEF_CFG_SVH
`define COEF_CFG_SVH

// ------------------------------------------------------------
// pages
// ------------------------------------------------------------
`define PAGE_COEF        8'h01
`define PAGE_ANALOG      8'h03
`define PAGE_TRIM        8'hfd

// ------------------------------------------------------------
// offsets
// ------------------------------------------------------------
`define OFS_COEF_CTRL    7'h01
`define OFS_COEF_ADDR    7'h02
`define OFS_WR_BYTE_HIGH 7'h04
`define OFS_WR_BYTE_MID  7'h05
`define OFS_WR_BYTE_LOW  7'h06
`define OFS_WR_EXT       7'h07
`define OFS_RD_BYTE_HIGH 7'h08
`define OFS_RD_BYTE_MID  7'h09
`define OFS_RD_BYTE_LOW  7'h0a
`define OFS_RD_EXT       7'h0b
`define OFS_OSC_CTRL     7'h12
`define OFS_BIAS_TRIM    7'h14
`define OFS_MIC_BIAS     7'h15

// ------------------------------------------------------------
// reset values and fields
// ------------------------------------------------------------
`define RST_ZERO         8'h00
`define RST_OSC_CTRL     8'h40
`define RST_MIC_BIAS     8'h01
`define BIT_WR_REQ       0
`define BIT_RD_REQ       1
`define BIT_BUSY         2
`define BIT_DONE         4
`define BIT_EXT          7
`define BIT_OSC_PD       0
`define BIT_MIC_ON       0
`define BIT_MIC_BYPASS   4
`define MSB_AMP_TRIM     7
`define MSB_GLB_TRIM     5

// ------------------------------------------------------------
// coefficient memory and timing
// ------------------------------------------------------------
`define COEF_AW          7
`define COEF_DW          25
`define COEF_ACCESS_CYC  4'h4

`endif

/* rtl/coef_pkg.sv */
// types used by the coefficient access engine for its state register
// assumes the constants header is included by the users
`default_nettype none
package coef_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_FINISH
	} eng_state_e;
endpackage
`default_nettype wire

/* rtl/coef_if.sv */
// link between the register bank and the coefficient access engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "coef_cfg.svh"
interface coef_if;
	logic                  wr_req;
	logic                  rd_req;
	logic [`COEF_AW-1:0]   addr;
	logic [`COEF_DW-1:0]   wdata;
	logic [`COEF_DW-1:0]   rdata;
	logic                  clr_wr;
	logic                  clr_rd;
	logic                  busy;
	logic                  done;

	modport engine (input wr_req, rd_req, addr, wdata,
		output rdata, clr_wr, clr_rd, busy, done);
	modport regs (output wr_req, rd_req, addr, wdata,
		input rdata, clr_wr, clr_rd, busy, done);
endinterface
`default_nettype wire

/* rtl/coef_engine.sv */
// coefficient memory with request, busy and done sequencing
// assumes requests arrive as levels held until cleared by this engine
`timescale 1ns/1ps
`default_nettype none
`include "coef_cfg.svh"
module coef_engine (
	input  wire logic  clk,
	input  wire logic  rst_b,
	coef_if.engine     cif
);
	coef_pkg::eng_state_e  state_q;
	coef_pkg::eng_state_e  state_d;
	logic [3:0]            cnt_q;
	logic                  op_wr_q;
	logic                  done_q;
	logic [`COEF_DW-1:0]   rdata_q;
	logic [`COEF_DW-1:0]   mem [0:(1<<`COEF_AW)-1];
	logic                  start;
	logic                  last;

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	assign start = (state_q == coef_pkg::ST_IDLE) & (cif.wr_req | cif.rd_req);
	assign last  = (state_q == coef_pkg::ST_RUN) & (cnt_q == 4'h1);

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			coef_pkg::ST_IDLE: begin
				if (start) state_d = coef_pkg::ST_RUN;
			end
			coef_pkg::ST_RUN: begin
				if (last) state_d = coef_pkg::ST_FINISH;
			end
			default: begin
				state_d = coef_pkg::ST_IDLE;
			end
		endcase
	end

	// state, counter, operation latch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= coef_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			op_wr_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= start ? `COEF_ACCESS_CYC : cnt_q - 4'h1;
			if (start) op_wr_q <= cif.wr_req; // write first if both
			done_q  <= last;
		end
	end

	// memory access at the last run cycle
	always_ff @(posedge clk) begin
		if (last && op_wr_q) mem[cif.addr] <= cif.wdata;
	end

	// read data capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= '0;
		end else if (last && !op_wr_q) begin
			rdata_q <= mem[cif.addr];
		end
	end

	// status back to the register bank
	assign cif.busy   = (state_q == coef_pkg::ST_RUN);
	assign cif.done   = done_q;
	assign cif.clr_wr = done_q & op_wr_q;
	assign cif.clr_rd = done_q & !op_wr_q;
	assign cif.rdata  = rdata_q;
endmodule
`default_nettype wire

/* rtl/coef_bias_regs.sv */
// register bank: coefficient access, oscillator, mic bias, bias trim
// assumes control port logic on SYS_CLK that gives page, address and
// single-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
`include "coef_cfg.svh"
module coef_bias_regs (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  REG_PAGE,
	input  wire logic [6:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	output logic             OSC_POWER_DOWN,
	output logic             MIC_BIAS_POWER_ON,
	output logic             MIC_BIAS_BYPASS,
	output logic      [1:0]  AMP_BIAS_TRIM,
	output logic      [1:0]  GLOBAL_BIAS_TRIM
);
	coef_if cif ();

	// storage and request flops
	logic [7:0]  ctrl_rsv_q;
	logic        wr_req_q;
	logic        rd_req_q;
	logic [7:0]  addr_q;
	logic [7:0]  wr_high_q;
	logic [7:0]  wr_mid_q;
	logic [7:0]  wr_low_q;
	logic [7:0]  wr_ext_q;
	logic [6:0]  rd_ext_rsv_q;
	logic [7:0]  osc_q;
	logic [7:0]  trim_q;
	logic [7:0]  mic_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rd_mux;
	logic [7:0]  ctrl_view;
	logic        pg_coef;
	logic        pg_ana;
	logic        pg_trim;
	logic        wr_ctrl;
	logic        set_wr;
	logic        set_rd;
	// one select per mapped register
	logic        sel_ctrl;
	logic        sel_addr;
	logic        sel_wr_high;
	logic        sel_wr_mid;
	logic        sel_wr_low;
	logic        sel_wr_ext;
	logic        sel_rd_high;
	logic        sel_rd_mid;
	logic        sel_rd_low;
	logic        sel_rd_ext;
	logic        sel_osc;
	logic        sel_mic;
	logic        sel_trim;

	// ------------------------------------------------------------
	// coefficient engine
	// ------------------------------------------------------------
	coef_engine u_engine (
		.clk   (SYS_CLK),
		.rst_b (RST_B),
		.cif   (cif.engine)
	);

	assign cif.wr_req = wr_req_q;
	assign cif.rd_req = rd_req_q;
	assign cif.addr   = addr_q[`COEF_AW-1:0];
	assign cif.wdata  = {wr_ext_q[`BIT_EXT], wr_high_q, wr_mid_q, wr_low_q};

	// ------------------------------------------------------------
	// page and register decode for writes and reads
	// ------------------------------------------------------------
	assign pg_coef = (REG_PAGE == `PAGE_COEF);
	assign pg_ana  = (REG_PAGE == `PAGE_ANALOG);
	assign pg_trim = (REG_PAGE == `PAGE_TRIM);

	// register selects from page and offset
	assign sel_ctrl    = pg_coef & (REG_ADDR == `OFS_COEF_CTRL);
	assign sel_addr    = pg_coef & (REG_ADDR == `OFS_COEF_ADDR);
	assign sel_wr_high = pg_coef & (REG_ADDR == `OFS_WR_BYTE_HIGH);
	assign sel_wr_mid  = pg_coef & (REG_ADDR == `OFS_WR_BYTE_MID);
	assign sel_wr_low  = pg_coef & (REG_ADDR == `OFS_WR_BYTE_LOW);
	assign sel_wr_ext  = pg_coef & (REG_ADDR == `OFS_WR_EXT);
	assign sel_rd_high = pg_coef & (REG_ADDR == `OFS_RD_BYTE_HIGH);
	assign sel_rd_mid  = pg_coef & (REG_ADDR == `OFS_RD_BYTE_MID);
	assign sel_rd_low  = pg_coef & (REG_ADDR == `OFS_RD_BYTE_LOW);
	assign sel_rd_ext  = pg_coef & (REG_ADDR == `OFS_RD_EXT);
	assign sel_osc     = pg_ana & (REG_ADDR == `OFS_OSC_CTRL);
	assign sel_mic     = pg_ana & (REG_ADDR == `OFS_MIC_BIAS);
	assign sel_trim    = pg_trim & (REG_ADDR == `OFS_BIAS_TRIM);

	// request bit strobes from a control register write
	assign wr_ctrl = REG_WR & sel_ctrl;
	assign set_wr  = wr_ctrl & REG_WDATA[`BIT_WR_REQ];
	assign set_rd  = wr_ctrl & REG_WDATA[`BIT_RD_REQ];

	// write request: host write wins over the engine clear
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_req_q <= 1'b0;
		end else if (wr_ctrl) begin
			wr_req_q <= set_wr;
		end else if (cif.clr_wr) begin
			wr_req_q <= 1'b0;
		end
	end

	// read request: host write wins over the engine clear
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_req_q <= 1'b0;
		end else if (wr_ctrl) begin
			rd_req_q <= set_rd;
		end else if (cif.clr_rd) begin
			rd_req_q <= 1'b0;
		end
	end

	// page 1 storage registers
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_rsv_q   <= `RST_ZERO;
			addr_q       <= `RST_ZERO;
			wr_high_q    <= `RST_ZERO;
			wr_mid_q     <= `RST_ZERO;
			wr_low_q     <= `RST_ZERO;
			wr_ext_q     <= `RST_ZERO;
			rd_ext_rsv_q <= 7'h00;
		end else if (REG_WR && pg_coef) begin
			if (REG_ADDR == `OFS_COEF_CTRL)
				ctrl_rsv_q <= REG_WDATA & 8'he8;
			else if (REG_ADDR == `OFS_COEF_ADDR)
				addr_q <= REG_WDATA;
			else if (REG_ADDR == `OFS_WR_BYTE_HIGH)
				wr_high_q <= REG_WDATA;
			else if (REG_ADDR == `OFS_WR_BYTE_MID)
				wr_mid_q <= REG_WDATA;
			else if (REG_ADDR == `OFS_WR_BYTE_LOW)
				wr_low_q <= REG_WDATA;
			else if (REG_ADDR == `OFS_WR_EXT)
				wr_ext_q <= REG_WDATA;
			else if (REG_ADDR == `OFS_RD_EXT)
				rd_ext_rsv_q <= REG_WDATA[6:0];
		end
	end

	// analog page and trim page registers
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			osc_q  <= `RST_OSC_CTRL;
			mic_q  <= `RST_MIC_BIAS;
			trim_q <= `RST_ZERO;
		end else if (REG_WR) begin
			if (pg_ana && REG_ADDR == `OFS_OSC_CTRL)
				osc_q <= REG_WDATA;
			else if (pg_ana && REG_ADDR == `OFS_MIC_BIAS)
				mic_q <= REG_WDATA;
			else if (pg_trim && REG_ADDR == `OFS_BIAS_TRIM)
				trim_q <= REG_WDATA;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	assign ctrl_view = {ctrl_rsv_q[7:5], cif.done, ctrl_rsv_q[3],
		cif.busy, rd_req_q, wr_req_q};

	// read selection; write-only mic bits read as zero
	always_comb begin
		rd_mux = 8'h00;
		if (sel_ctrl)
			rd_mux = ctrl_view;
		else if (sel_addr)
			rd_mux = addr_q;
		else if (sel_wr_high)
			rd_mux = wr_high_q;
		else if (sel_wr_mid)
			rd_mux = wr_mid_q;
		else if (sel_wr_low)
			rd_mux = wr_low_q;
		else if (sel_wr_ext)
			rd_mux = wr_ext_q;
		else if (sel_rd_high)
			rd_mux = cif.rdata[23:16];
		else if (sel_rd_mid)
			rd_mux = cif.rdata[15:8];
		else if (sel_rd_low)
			rd_mux = cif.rdata[7:0];
		else if (sel_rd_ext)
			rd_mux = {cif.rdata[24], rd_ext_rsv_q};
		else if (sel_osc)
			rd_mux = osc_q;
		else if (sel_mic)
			rd_mux = mic_q & 8'hee;
		else if (sel_trim)
			rd_mux = trim_q;
	end

	// read data and control outputs, all from flops
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 8'h00;
		end else if (REG_RD) begin
			rdata_q <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// each output is a flop or a bit of one
	assign REG_RDATA         = rdata_q;
	assign OSC_POWER_DOWN    = osc_q[`BIT_OSC_PD];
	assign MIC_BIAS_POWER_ON = mic_q[`BIT_MIC_ON];
	assign MIC_BIAS_BYPASS   = mic_q[`BIT_MIC_BYPASS];
	assign AMP_BIAS_TRIM     = trim_q[`MSB_AMP_TRIM -: 2];
	assign GLOBAL_BIAS_TRIM  = trim_q[`MSB_GLB_TRIM -: 2];
endmodule
`default_nettype wire

/* sim/coef_bias_props.sv */
// assertions on the ports of the register bank
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module coef_bias_props (
	input wire logic       SYS_CLK,
	input wire logic       RST_B,
	input wire logic [7:0] REG_PAGE,
	input wire logic [6:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic       OSC_POWER_DOWN,
	input wire logic       MIC_BIAS_POWER_ON,
	input wire logic       MIC_BIAS_BYPASS,
	input wire logic [1:0] AMP_BIAS_TRIM,
	input wire logic [1:0] GLOBAL_BIAS_TRIM
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	// strobes aimed at single registers
	wire osc_wr = REG_WR && REG_PAGE == 8'h03 && REG_ADDR == 7'h12;
	wire mic_wr = REG_WR && REG_PAGE == 8'h03 && REG_ADDR == 7'h15;
	wire trm_wr = REG_WR && REG_PAGE == 8'hfd && REG_ADDR == 7'h14;
	wire mic_rd = REG_RD && REG_PAGE == 8'h03 && REG_ADDR == 7'h15;
	wire ctl_rd = REG_RD && REG_PAGE == 8'h01 && REG_ADDR == 7'h01;

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	// two quiet cycles on the mic register
	sequence s_mic_quiet;
		!mic_wr [*2];
	endsequence

	a_osc_follows: assert property (
		osc_wr |=> OSC_POWER_DOWN == $past(REG_WDATA[0]))
		else $error("osc power bit not loaded");
	a_osc_holds: assert property (
		!osc_wr |=> $stable(OSC_POWER_DOWN))
		else $error("osc power bit moved");
	a_mic_on_load: assert property (
		mic_wr |=> MIC_BIAS_POWER_ON == $past(REG_WDATA[0]))
		else $error("mic power bit not loaded");
	a_bypass_load: assert property (
		mic_wr |=> MIC_BIAS_BYPASS == $past(REG_WDATA[4]))
		else $error("bypass bit not loaded");
	a_mic_steady: assert property (
		s_mic_quiet |-> $stable({MIC_BIAS_POWER_ON, MIC_BIAS_BYPASS}))
		else $error("mic bits moved");
	a_trim_load: assert property (
		trm_wr |=>
		{AMP_BIAS_TRIM, GLOBAL_BIAS_TRIM} == $past(REG_WDATA[7:4]))
		else $error("trim fields not loaded");
	a_wo_read_zero: assert property (
		mic_rd |=> REG_RDATA[4] == 1'b0 && REG_RDATA[0] == 1'b0)
		else $error("write-only bits read back");
	a_rdata_holds: assert property (
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without read");
	a_busy_not_done: assert property (
		ctl_rd |=> !(REG_RDATA[2] && REG_RDATA[4]))
		else $error("busy and done together");
endmodule
bind coef_bias_regs coef_bias_props u_props (.SYS_CLK, .RST_B, .REG_PAGE,
	.REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .OSC_POWER_DOWN,
	.MIC_BIAS_POWER_ON, .MIC_BIAS_BYPASS, .AMP_BIAS_TRIM, .GLOBAL_BIAS_TRIM);
`default_nettype wire

/* sim/tb_coef_bias_regs.sv */
// self-checking bench for the coefficient and bias register bank
// assumes the design files and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_coef_bias_regs;
	logic       SYS_CLK   = 1'h0;
	logic       RST_B     = 1'h0;
	logic [7:0] REG_PAGE  = 8'h00;
	logic [6:0] REG_ADDR  = 7'h00;
	logic       REG_WR    = 1'h0;
	logic [7:0] REG_WDATA = 8'h00;
	logic       REG_RD    = 1'h0;
	logic [7:0] REG_RDATA;
	logic       OSC_POWER_DOWN;
	logic       MIC_BIAS_POWER_ON;
	logic       MIC_BIAS_BYPASS;
	logic [1:0] AMP_BIAS_TRIM;
	logic [1:0] GLOBAL_BIAS_TRIM;
	int         errors    = 0;
	int         n_checks  = 0;
	int         cyc       = 0;

	coef_bias_regs dut (.SYS_CLK, .RST_B, .REG_PAGE, .REG_ADDR, .REG_WR,
		.REG_WDATA, .REG_RD, .REG_RDATA, .OSC_POWER_DOWN,
		.MIC_BIAS_POWER_ON, .MIC_BIAS_BYPASS, .AMP_BIAS_TRIM,
		.GLOBAL_BIAS_TRIM);

	// ----------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------
	// 25 ns period
	initial begin
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	// cut a hang short
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			finish_test();
		end
	end
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic wr(input logic [7:0] pg, input logic [6:0] ad,
		input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_PAGE <= pg;
		REG_ADDR <= ad;
		REG_WDATA <= d;
		REG_WR <= 1'h1;
		@(posedge SYS_CLK);
		REG_WR <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [7:0] pg, input logic [6:0] ad,
		input logic [7:0] e);
		@(posedge SYS_CLK);
		REG_PAGE <= pg;
		REG_ADDR <= ad;
		REG_RD <= 1'h1;
		@(posedge SYS_CLK);
		REG_RD <= 1'h0;
		#1 `CHK(REG_RDATA, e)
	endtask
	// control register read every cycle after a request; the read
	// flop shows the status one cycle after it stood
	task automatic walk(input logic [7:0] rq);
		logic [7:0] want;
		@(posedge SYS_CLK);
		REG_PAGE <= 8'h01;
		REG_ADDR <= 7'h01;
		REG_RD <= 1'h1;
		for (int i = 2; i < 8; i++) begin
			want = i < 6 ? rq | 8'h04 : (i == 6 ? rq | 8'h10 : 8'h00);
			@(posedge SYS_CLK);
			#1 `CHK(REG_RDATA, want)
		end
		@(posedge SYS_CLK);
		REG_RD <= 1'h0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		`CHK(OSC_POWER_DOWN, 1'h0)
		`CHK(MIC_BIAS_POWER_ON, 1'h1)
		`CHK(MIC_BIAS_BYPASS, 1'h0)
		`CHK({AMP_BIAS_TRIM, GLOBAL_BIAS_TRIM}, 4'h0)
		for (int a = 1; a < 12; a++)
			rd(8'h01, 7'(a), 8'h00);
		rd(8'h03, 7'h12, 8'h40);
		rd(8'h03, 7'h15, 8'h00);
		rd(8'hfd, 7'h14, 8'h00);
		rd(8'h02, 7'h12, 8'h00);
	endtask
	task automatic t_analog;
		wr(8'h03, 7'h12, 8'h41);
		`CHK(OSC_POWER_DOWN, 1'h1)
		rd(8'h03, 7'h12, 8'h41);
		wr(8'h01, 7'h12, 8'h40);
		`CHK(OSC_POWER_DOWN, 1'h1)
		wr(8'h03, 7'h12, 8'h40);
		`CHK(OSC_POWER_DOWN, 1'h0)
		wr(8'h03, 7'h15, 8'h10);
		`CHK({MIC_BIAS_BYPASS, MIC_BIAS_POWER_ON}, 2'h2)
		rd(8'h03, 7'h15, 8'h00);
		wr(8'h03, 7'h15, 8'h01);
		`CHK({MIC_BIAS_BYPASS, MIC_BIAS_POWER_ON}, 2'h1)
		for (int k = 0; k < 4; k++) begin
			wr(8'hfd, 7'h14, {2'(k), 2'(3 - k), 4'h0});
			`CHK(AMP_BIAS_TRIM, 2'(k))
			`CHK(GLOBAL_BIAS_TRIM, 2'(3 - k))
		end
		rd(8'hfd, 7'h14, 8'hc0);
	endtask
	task automatic t_coef;
		wr(8'h01, 7'h02, 8'h05);
		wr(8'h01, 7'h04, 8'h12);
		wr(8'h01, 7'h05, 8'h34);
		wr(8'h01, 7'h06, 8'h56);
		wr(8'h01, 7'h07, 8'h80);
		rd(8'h01, 7'h06, 8'h56);
		rd(8'h01, 7'h07, 8'h80);
		wr(8'h01, 7'h01, 8'h01);
		walk(8'h01);
		wr(8'h01, 7'h07, 8'h00);
		wr(8'h01, 7'h01, 8'h02);
		walk(8'h02);
		rd(8'h01, 7'h08, 8'h12);
		rd(8'h01, 7'h09, 8'h34);
		rd(8'h01, 7'h0a, 8'h56);
		rd(8'h01, 7'h0b, 8'h80);
		wr(8'h01, 7'h08, 8'hff);
		rd(8'h01, 7'h08, 8'h12);
		wr(8'h01, 7'h0b, 8'h00);
		rd(8'h01, 7'h0b, 8'h80);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge SYS_CLK);
		RST_B <= 1'h1;
		t_reset();
		t_analog();
		t_coef();
		finish_test();
	end
endmodule
`default_nettype wire
